// ---- design/ppm_defs.svh ----
// Constants for the pin multiplexer of ports 0, 2 and 3
`ifndef PPM_DEFS_SVH
`define PPM_DEFS_SVH

`define PPM_P0_W 8
`define PPM_P2_W 8
`define PPM_P3_W 7

// Reset values: all inputs, port mode, no pull-ups, latches low
`define PPM_P0_DIR_RST 8'hFF
`define PPM_P2_DIR_RST 8'hFF
`define PPM_P3_DIR_RST 7'h7F
`define PPM_P0_ZERO 8'h00
`define PPM_P2_ZERO 8'h00
`define PPM_P3_ZERO 7'h00
`define PPM_SEL_ZERO 16'h0000

// Shared port bit positions
`define PPM_P2_SIB 0
`define PPM_P2_SOB 1
`define PPM_P2_SCKB 2
`define PPM_P2_TMA 3
`define PPM_P2_RX 4
`define PPM_P2_TX 5
`define PPM_P2_TMC 6
`define PPM_P2_TMB 7

// Seven-pin port bit positions
`define PPM_P3_SIA 0
`define PPM_P3_SOA 1
`define PPM_P3_SCKA 2
`define PPM_P3_OD 3
`define PPM_P3_WOUT 4
`define PPM_P3_WCLK 5
`define PPM_P3_WCAP 6

`endif

// ---- design/ppm_pkg.sv ----
// Types for the pin multiplexer of ports 0, 2 and 3
package ppm_pkg;
  // Valid edge of an external interrupt input; bit 0 rising, bit 1 falling
  typedef enum logic [1:0] {
    PPM_EDGE_NONE = 2'h0,
    PPM_EDGE_RISE = 2'h1,
    PPM_EDGE_BOTH = 2'h3,
    PPM_EDGE_FALL = 2'h2
  } ppm_edge_e;
endpackage

// ---- design/ppm_sync_if.sv ----
// Synchronised pin levels and edges passed from the input stage to the mux
`timescale 1ns/1ps
interface ppm_sync_if #(parameter int W = 8);
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// ---- design/ppm_insync.sv ----
// Two-stage pin synchroniser with edge detection for one port
`timescale 1ns/1ps
module ppm_insync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  ppm_sync_if.src sy
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;
  logic [2:0] warm_r;

  // First stage is read only by the second, to keep metastability contained
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edges stay masked until prev_r holds a real pin sample, so a pin idling
  // high gives no false rise just after reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      warm_r <= '0;
    else
      warm_r <= {warm_r[1:0], 1'b1};
  end

  // Edges are one cycle long, seen on the synchronised level only
  assign sy.level = sync_r;
  assign sy.rise = sync_r & ~prev_r & {W{warm_r[2]}};
  assign sy.fall = ~sync_r & prev_r & {W{warm_r[2]}};
endmodule

// ---- design/ppm_top.sv ----
// Pin direction, pull-up and alternate-function mux for ports 0, 2 and 3
// Summary of operation
// RULE_01 - Interrupt port: eight pins, each direction set by its own bit.
// RULE_02 - Interrupt port pull-up enabled per bit by its pull-up option bit.
// RULE_03 - Control mode: eight external interrupts, rising, falling or both edges.
// RULE_04 - Each pin switches alone between port mode and control mode.
// RULE_05 - Shared port: eight pins, each direction set by its own bit.
// RULE_06 - Shared port pull-up enabled per bit by its pull-up option bit.
// RULE_07 - Shared port carries clocked serial, async serial and three byte timers.
// RULE_08 - Seven-pin port: each direction set by its own bit.
// RULE_09 - Seven-pin port bit 3 is open drain: drives only low.
// RULE_10 - Seven-pin port pull-up enabled per bit by its pull-up option bit.
// RULE_11 - Seven-pin port carries second clocked serial and the wide timer.
// RULE_12 - Wide timer primary pin: count clock and trigger of both captures.
// RULE_13 - Wide timer secondary pin triggers only the first capture.
// RULE_14 - Wide timer output goes to seven-pin port bit 4 in control mode.
// RULE_15 - After reset all pins are port-mode inputs with pull-ups off.
`timescale 1ns/1ps
`include "ppm_defs.svh"
module ppm_top (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [7:0] IRQ_PORT_DIR,
  input wire logic [7:0] IRQ_PORT_PULLUP,
  input wire logic [7:0] IRQ_PORT_MODE,
  input wire logic [7:0] IRQ_PORT_LATCH,
  input wire logic [15:0] IRQ_EDGE_SEL,
  output logic [7:0] IRQ_PORT_READ,
  output logic [7:0] EXT_IRQ_INPUTS,
  input wire logic [7:0] IRQ_PIN_IN,
  output logic [7:0] IRQ_PIN_OUT,
  output logic [7:0] IRQ_PIN_OE,
  output logic [7:0] IRQ_PULLUP_EN,
  input wire logic [7:0] SHARED_PORT_DIR,
  input wire logic [7:0] SHARED_PORT_PULLUP,
  input wire logic [7:0] SHARED_PORT_MODE,
  input wire logic [7:0] SHARED_PORT_LATCH,
  output logic [7:0] SHARED_PORT_READ,
  input wire logic [7:0] SHARED_PIN_IN,
  output logic [7:0] SHARED_PIN_OUT,
  output logic [7:0] SHARED_PIN_OE,
  output logic [7:0] SHARED_PULLUP_EN,
  input wire logic [6:0] SEVEN_PORT_DIR,
  input wire logic [6:0] SEVEN_PORT_PULLUP,
  input wire logic [6:0] SEVEN_PORT_MODE,
  input wire logic [6:0] SEVEN_PORT_LATCH,
  output logic [6:0] SEVEN_PORT_READ,
  input wire logic [6:0] SEVEN_PIN_IN,
  output logic [6:0] SEVEN_PIN_OUT,
  output logic [6:0] SEVEN_PIN_OE,
  output logic [6:0] SEVEN_PULLUP_EN,
  output logic SYNC_SERIAL_B_DIN,
  input wire logic SYNC_SERIAL_B_DOUT,
  input wire logic SYNC_SERIAL_B_CLK_OUT,
  output logic SYNC_SERIAL_B_CLK,
  output logic ASYNC_SERIAL_RX,
  input wire logic ASYNC_SERIAL_TX,
  output logic ASYNC_SERIAL_CLK_IN,
  output logic BYTE_TIMER_A_CLK_IN,
  output logic BYTE_TIMER_B_CLK_IN,
  output logic BYTE_TIMER_C_CLK_IN,
  input wire logic BYTE_TIMER_A_OUT,
  input wire logic BYTE_TIMER_B_OUT,
  input wire logic BYTE_TIMER_C_OUT,
  output logic SYNC_SERIAL_A_DIN,
  input wire logic SYNC_SERIAL_A_DOUT,
  input wire logic SYNC_SERIAL_A_CLK_OUT,
  output logic SYNC_SERIAL_A_CLK,
  input wire logic WIDE_TIMER_OUT,
  output logic WIDE_TIMER_CLK_TICK,
  output logic WIDE_TIMER_CAPTURE_FIRST_TRIG,
  output logic WIDE_TIMER_CAPTURE_SECOND_TRIG
);
  logic [7:0] dir0_r, pu0_r, mode0_r, lat0_r;
  logic [7:0] dir2_r, pu2_r, mode2_r, lat2_r;
  logic [6:0] dir3_r, pu3_r, mode3_r, lat3_r;
  logic [15:0] sel_r;
  logic [7:0] alt2;
  logic [6:0] alt3;
  logic [7:0] irq_hit;

  ppm_sync_if #(.W(`PPM_P0_W)) s0 ();
  ppm_sync_if #(.W(`PPM_P2_W)) s2 ();
  ppm_sync_if #(.W(`PPM_P3_W)) s3 ();

  // Pins come from the board, so every port passes the synchroniser first
  ppm_insync #(.W(`PPM_P0_W)) u_sync0 (.clk(CLK), .rst_n(RSTN), .pin(IRQ_PIN_IN), .sy(s0));
  ppm_insync #(.W(`PPM_P2_W)) u_sync2 (.clk(CLK), .rst_n(RSTN), .pin(SHARED_PIN_IN), .sy(s2));
  ppm_insync #(.W(`PPM_P3_W)) u_sync3 (.clk(CLK), .rst_n(RSTN), .pin(SEVEN_PIN_IN), .sy(s3));

  // Configuration held in flops so reset gives inputs, port mode, no pull-ups
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      dir0_r <= `PPM_P0_DIR_RST; // [RULE_15]
      pu0_r <= `PPM_P0_ZERO;
      mode0_r <= `PPM_P0_ZERO;
      lat0_r <= `PPM_P0_ZERO;
      dir2_r <= `PPM_P2_DIR_RST;
      pu2_r <= `PPM_P2_ZERO;
      mode2_r <= `PPM_P2_ZERO;
      lat2_r <= `PPM_P2_ZERO;
      dir3_r <= `PPM_P3_DIR_RST;
      pu3_r <= `PPM_P3_ZERO;
      mode3_r <= `PPM_P3_ZERO;
      lat3_r <= `PPM_P3_ZERO;
      sel_r <= `PPM_SEL_ZERO;
    end
    else
    begin
      dir0_r <= IRQ_PORT_DIR;
      pu0_r <= IRQ_PORT_PULLUP;
      mode0_r <= IRQ_PORT_MODE; // [RULE_04]
      lat0_r <= IRQ_PORT_LATCH;
      dir2_r <= SHARED_PORT_DIR;
      pu2_r <= SHARED_PORT_PULLUP;
      mode2_r <= SHARED_PORT_MODE;
      lat2_r <= SHARED_PORT_LATCH;
      dir3_r <= SEVEN_PORT_DIR;
      pu3_r <= SEVEN_PORT_PULLUP;
      mode3_r <= SEVEN_PORT_MODE;
      lat3_r <= SEVEN_PORT_LATCH;
      sel_r <= IRQ_EDGE_SEL;
    end
  end

  // Alternate outputs; input-only functions leave zero, direction decides the pin
  always_comb
  begin
    alt2 = `PPM_P2_ZERO;
    alt2[`PPM_P2_SOB] = SYNC_SERIAL_B_DOUT; // [RULE_07]
    alt2[`PPM_P2_SCKB] = SYNC_SERIAL_B_CLK_OUT;
    alt2[`PPM_P2_TMA] = BYTE_TIMER_A_OUT;
    alt2[`PPM_P2_TX] = ASYNC_SERIAL_TX;
    alt2[`PPM_P2_TMC] = BYTE_TIMER_C_OUT;
    alt2[`PPM_P2_TMB] = BYTE_TIMER_B_OUT;
    alt3 = `PPM_P3_ZERO;
    alt3[`PPM_P3_SOA] = SYNC_SERIAL_A_DOUT; // [RULE_11]
    alt3[`PPM_P3_SCKA] = SYNC_SERIAL_A_CLK_OUT;
    alt3[`PPM_P3_WOUT] = WIDE_TIMER_OUT; // [RULE_14]
  end

  // Per-bit valid edge; the edge code doubles as a rise/fall mask
  always_comb
  begin
    for (int i = 0; i < `PPM_P0_W; i++)
    begin
      irq_hit[i] = mode0_r[i] & ((sel_r[2*i] & s0.rise[i]) | (sel_r[2*i+1] & s0.fall[i]));
    end
  end

  // Pin drivers: output enable high while the pin is an output
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      IRQ_PIN_OUT <= `PPM_P0_ZERO;
      IRQ_PIN_OE <= `PPM_P0_ZERO;
      SHARED_PIN_OUT <= `PPM_P2_ZERO;
      SHARED_PIN_OE <= `PPM_P2_ZERO;
      SEVEN_PIN_OUT <= `PPM_P3_ZERO;
      SEVEN_PIN_OE <= `PPM_P3_ZERO;
    end
    else
    begin
      IRQ_PIN_OUT <= lat0_r; // Interrupt function is input only
      IRQ_PIN_OE <= ~dir0_r; // [RULE_01]
      SHARED_PIN_OUT <= (mode2_r & alt2) | (~mode2_r & lat2_r); // [RULE_04]
      SHARED_PIN_OE <= ~dir2_r; // [RULE_05]
      SEVEN_PIN_OUT <= (mode3_r & alt3) | (~mode3_r & lat3_r);
      SEVEN_PIN_OE <= ~dir3_r; // [RULE_08]
      // Open drain: never drive high, only enable while pulling low
      SEVEN_PIN_OUT[`PPM_P3_OD] <= 1'b0; // [RULE_09]
      SEVEN_PIN_OE[`PPM_P3_OD] <= ~dir3_r[`PPM_P3_OD] & ~lat3_r[`PPM_P3_OD]; // [RULE_09]
    end
  end

  // Pull-up controls follow the option bits directly
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      IRQ_PULLUP_EN <= `PPM_P0_ZERO;
      SHARED_PULLUP_EN <= `PPM_P2_ZERO;
      SEVEN_PULLUP_EN <= `PPM_P3_ZERO;
    end
    else
    begin
      IRQ_PULLUP_EN <= pu0_r; // [RULE_02]
      SHARED_PULLUP_EN <= pu2_r; // [RULE_06]
      SEVEN_PULLUP_EN <= pu3_r; // [RULE_10]
    end
  end

  // Read-back of pin levels and interrupt requests
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      IRQ_PORT_READ <= `PPM_P0_ZERO;
      SHARED_PORT_READ <= `PPM_P2_ZERO;
      SEVEN_PORT_READ <= `PPM_P3_ZERO;
      EXT_IRQ_INPUTS <= `PPM_P0_ZERO;
    end
    else
    begin
      IRQ_PORT_READ <= s0.level;
      SHARED_PORT_READ <= s2.level;
      SEVEN_PORT_READ <= s3.level;
      EXT_IRQ_INPUTS <= irq_hit; // [RULE_03]
    end
  end

  // Peripheral inputs: levels gated by control mode so port use cannot disturb them
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      SYNC_SERIAL_B_DIN <= 1'b0;
      SYNC_SERIAL_B_CLK <= 1'b0;
      ASYNC_SERIAL_RX <= 1'b0;
      ASYNC_SERIAL_CLK_IN <= 1'b0;
      BYTE_TIMER_A_CLK_IN <= 1'b0;
      BYTE_TIMER_B_CLK_IN <= 1'b0;
      BYTE_TIMER_C_CLK_IN <= 1'b0;
      SYNC_SERIAL_A_DIN <= 1'b0;
      SYNC_SERIAL_A_CLK <= 1'b0;
    end
    else
    begin
      SYNC_SERIAL_B_DIN <= mode2_r[`PPM_P2_SIB] & s2.level[`PPM_P2_SIB]; // [RULE_07]
      SYNC_SERIAL_B_CLK <= mode2_r[`PPM_P2_SCKB] & s2.level[`PPM_P2_SCKB];
      ASYNC_SERIAL_RX <= mode2_r[`PPM_P2_RX] & s2.level[`PPM_P2_RX];
      ASYNC_SERIAL_CLK_IN <= mode2_r[`PPM_P2_TMC] & s2.level[`PPM_P2_TMC];
      BYTE_TIMER_A_CLK_IN <= mode2_r[`PPM_P2_TMA] & s2.level[`PPM_P2_TMA];
      BYTE_TIMER_B_CLK_IN <= mode2_r[`PPM_P2_TMB] & s2.level[`PPM_P2_TMB];
      BYTE_TIMER_C_CLK_IN <= mode2_r[`PPM_P2_TMC] & s2.level[`PPM_P2_TMC];
      SYNC_SERIAL_A_DIN <= mode3_r[`PPM_P3_SIA] & s3.level[`PPM_P3_SIA]; // [RULE_11]
      SYNC_SERIAL_A_CLK <= mode3_r[`PPM_P3_SCKA] & s3.level[`PPM_P3_SCKA];
    end
  end

  // Wide timer triggers: one-cycle pulses on rising edges of the two inputs
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      WIDE_TIMER_CLK_TICK <= 1'b0;
      WIDE_TIMER_CAPTURE_FIRST_TRIG <= 1'b0;
      WIDE_TIMER_CAPTURE_SECOND_TRIG <= 1'b0;
    end
    else
    begin
      WIDE_TIMER_CLK_TICK <= mode3_r[`PPM_P3_WCLK] & s3.rise[`PPM_P3_WCLK]; // [RULE_12]
      WIDE_TIMER_CAPTURE_SECOND_TRIG <= mode3_r[`PPM_P3_WCLK] & s3.rise[`PPM_P3_WCLK];
      WIDE_TIMER_CAPTURE_FIRST_TRIG <= (mode3_r[`PPM_P3_WCLK] & s3.rise[`PPM_P3_WCLK])
        | (mode3_r[`PPM_P3_WCAP] & s3.rise[`PPM_P3_WCAP]); // [RULE_13]
    end
  end

  a_irq_dir: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_01]
    $past(RSTN, 2) |-> IRQ_PIN_OE == ~$past(IRQ_PORT_DIR, 2))
    else $error("interrupt port enable does not follow direction");
  a_irq_pullup: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_02]
    $past(RSTN, 2) |-> IRQ_PULLUP_EN == $past(IRQ_PORT_PULLUP, 2))
    else $error("interrupt port pull-up does not follow option");
  a_irq_mode_gate: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_03]
    (EXT_IRQ_INPUTS & ~$past(mode0_r)) == `PPM_P0_ZERO)
    else $error("interrupt request from a port-mode pin");
  a_irq_rise_hit: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_03]
    (mode0_r[0] && sel_r[1:0] == ppm_pkg::PPM_EDGE_BOTH && s0.rise[0]) |=> EXT_IRQ_INPUTS[0])
    else $error("both-edge interrupt missed a rising edge");
  a_shared_dir: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_05]
    $past(RSTN, 2) |-> SHARED_PIN_OE == ~$past(SHARED_PORT_DIR, 2))
    else $error("shared port enable does not follow direction");
  a_shared_tx: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_07]
    $past(mode2_r[`PPM_P2_TX]) |-> SHARED_PIN_OUT[`PPM_P2_TX] == $past(ASYNC_SERIAL_TX))
    else $error("async transmit not on its pin in control mode");
  a_seven_dir: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_08]
    $past(RSTN, 2) |-> SEVEN_PIN_OE[2:0] == ~$past(SEVEN_PORT_DIR[2:0], 2))
    else $error("seven-pin port enable does not follow direction");
  a_open_drain: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_09]
    SEVEN_PIN_OUT[`PPM_P3_OD] == 1'b0 && (!SEVEN_PIN_OE[`PPM_P3_OD] || !$past(lat3_r[`PPM_P3_OD])))
    else $error("open-drain bit driven high");
  a_seven_pullup: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_10]
    $past(RSTN, 2) |-> SEVEN_PULLUP_EN == $past(SEVEN_PORT_PULLUP, 2))
    else $error("seven-pin pull-up does not follow option");
  a_wide_out: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_14]
    $past(mode3_r[`PPM_P3_WOUT]) |-> SEVEN_PIN_OUT[`PPM_P3_WOUT] == $past(WIDE_TIMER_OUT))
    else $error("wide timer output not on bit 4");
  a_cap_primary: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_12]
    WIDE_TIMER_CLK_TICK |-> WIDE_TIMER_CAPTURE_FIRST_TRIG && WIDE_TIMER_CAPTURE_SECOND_TRIG)
    else $error("primary input did not trigger both captures");
  a_cap_second: assert property (@(posedge CLK) disable iff (!RSTN) // [RULE_13]
    (mode3_r[`PPM_P3_WCAP] && s3.rise[`PPM_P3_WCAP] && !s3.rise[`PPM_P3_WCLK])
      |=> WIDE_TIMER_CAPTURE_FIRST_TRIG && !WIDE_TIMER_CAPTURE_SECOND_TRIG)
    else $error("second capture triggered by the secondary input");
endmodule

// ---- tb/ppm_board.sv ----
// Board-side pad model: resolves each pin from device drive, board drive and pull-up
`timescale 1ns/1ps
module ppm_board #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] dout,
  input wire logic [W-1:0] pu,
  input wire logic [W-1:0] brd_en,
  input wire logic [W-1:0] brd_val,
  output logic [W-1:0] pin
);
  logic [W-1:0] flt_r = '0;
  // A floating pad flips every cycle, so a stale level can never pass for a driven one
  always_ff @(posedge clk)
    flt_r <= ~pin;
  // Device drive wins, then the board, then the pull-up
  assign pin = (oe & dout) | (~oe & brd_en & brd_val) | (~oe & ~brd_en & (pu | flt_r));
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the three-port pin multiplexer with board pad models
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [2:0] kind;
    logic [1:0] k;
    logic [7:0] m;
    logic [7:0] e;
  } ppm_chk_s;
  localparam logic [7:0] am [3] = '{8'h00, 8'hEE, 8'h16};
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [15:0] sel = 16'h0000;
  logic [7:0] dir [3] = '{default: 8'h00};
  logic [7:0] pu [3] = '{default: 8'h00};
  logic [7:0] md [3] = '{default: 8'h00};
  logic [7:0] lt [3] = '{default: 8'h00};
  logic [7:0] be [3] = '{default: 8'h00};
  logic [7:0] bv [3] = '{default: 8'h00};
  logic [7:0] alt [3] = '{default: 8'h00};
  wire [7:0] oe [3];
  wire [7:0] ou [3];
  wire [7:0] pe [3];
  wire [7:0] rd [3];
  wire [7:0] pin [3];
  wire [10:0] pvn;
  wire [7:0] pv8;
  wire a_clk;
  ppm_chk_s lq [$];
  ppm_chk_s cq;
  logic [10:0] pq [$];
  logic [31:0] lf = 32'h8e08_7357;
  int err_count = 0;
  int num_checks = 0;

  always #20 CLK = ~CLK;

  ppm_top dut (
    .CLK(CLK), .RSTN(RSTN), .IRQ_EDGE_SEL(sel), .EXT_IRQ_INPUTS(pvn[7:0]),
    .IRQ_PORT_DIR(dir[0]), .IRQ_PORT_PULLUP(pu[0]), .IRQ_PORT_MODE(md[0]),
    .IRQ_PORT_LATCH(lt[0]), .IRQ_PORT_READ(rd[0]), .IRQ_PIN_IN(pin[0]),
    .IRQ_PIN_OUT(ou[0]), .IRQ_PIN_OE(oe[0]), .IRQ_PULLUP_EN(pe[0]),
    .SHARED_PORT_DIR(dir[1]), .SHARED_PORT_PULLUP(pu[1]), .SHARED_PORT_MODE(md[1]),
    .SHARED_PORT_LATCH(lt[1]), .SHARED_PORT_READ(rd[1]), .SHARED_PIN_IN(pin[1]),
    .SHARED_PIN_OUT(ou[1]), .SHARED_PIN_OE(oe[1]), .SHARED_PULLUP_EN(pe[1]),
    .SEVEN_PORT_DIR(dir[2][6:0]), .SEVEN_PORT_PULLUP(pu[2][6:0]), .SEVEN_PORT_MODE(md[2][6:0]),
    .SEVEN_PORT_LATCH(lt[2][6:0]), .SEVEN_PORT_READ(rd[2][6:0]), .SEVEN_PIN_IN(pin[2][6:0]),
    .SEVEN_PIN_OUT(ou[2][6:0]), .SEVEN_PIN_OE(oe[2][6:0]), .SEVEN_PULLUP_EN(pe[2][6:0]),
    .SYNC_SERIAL_B_DIN(pv8[7]), .SYNC_SERIAL_B_DOUT(alt[1][1]),
    .SYNC_SERIAL_B_CLK_OUT(alt[1][2]), .SYNC_SERIAL_B_CLK(pv8[6]), .ASYNC_SERIAL_RX(pv8[5]),
    .ASYNC_SERIAL_TX(alt[1][5]), .ASYNC_SERIAL_CLK_IN(pv8[4]), .BYTE_TIMER_A_CLK_IN(pv8[3]),
    .BYTE_TIMER_B_CLK_IN(pv8[2]), .BYTE_TIMER_C_CLK_IN(pv8[1]), .BYTE_TIMER_A_OUT(alt[1][3]),
    .BYTE_TIMER_B_OUT(alt[1][7]), .BYTE_TIMER_C_OUT(alt[1][6]), .SYNC_SERIAL_A_DIN(pv8[0]),
    .SYNC_SERIAL_A_DOUT(alt[2][1]), .SYNC_SERIAL_A_CLK_OUT(alt[2][2]), .SYNC_SERIAL_A_CLK(a_clk),
    .WIDE_TIMER_OUT(alt[2][4]), .WIDE_TIMER_CLK_TICK(pvn[10]),
    .WIDE_TIMER_CAPTURE_FIRST_TRIG(pvn[9]), .WIDE_TIMER_CAPTURE_SECOND_TRIG(pvn[8])
  );

  // One pad model per port; the seven-pin port leaves its top bit unused
  for (genvar g = 0; g < 3; g++)
  begin : g_brd
    ppm_board #(.W(8)) u_brd (.clk(CLK), .oe(oe[g]), .dout(ou[g]), .pu(pe[g]),
      .brd_en(be[g]), .brd_val(bv[g]), .pin(pin[g]));
  end

  // The seven-pin port has no bit 7; tie it so no net is left undriven
  assign oe[2][7] = 1'b0;
  assign ou[2][7] = 1'b0;
  assign pe[2][7] = 1'b0;
  assign rd[2][7] = 1'b0;

  function automatic logic [7:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction

  function automatic logic [7:0] pick(input ppm_chk_s c);
    case (c.kind)
      3'h0: return oe[c.k];
      3'h1: return ou[c.k];
      3'h2: return pe[c.k];
      3'h3: return rd[c.k];
      default: return (c.k == 2'h0) ? pv8 : {7'h00, a_clk};
    endcase
  endfunction

  task automatic chk(input logic [2:0] kind, input logic [1:0] k, input logic [7:0] m,
                     input logic [7:0] e);
    lq.push_back(ppm_chk_s'{kind, k, m, e});
  endtask

  task automatic cmp_lvl(input logic [7:0] a, input logic [7:0] e);
    num_checks++;
    if (a !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t level got %h exp %h", $time, a, e);
    end
  endtask

  task automatic cmp_pls(input logic [10:0] a, input logic [10:0] e);
    num_checks++;
    if (a !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t pulse got %h exp %h", $time, a, e);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Outputs are read at the falling edge, well away from the launching edge
  always @(negedge CLK)
  begin
    while (lq.size() > 0)
    begin
      cq = lq.pop_front();
      cmp_lvl(pick(cq) & cq.m, cq.e & cq.m);
    end
    if (RSTN === 1'b1 && pvn !== 11'h000)
      cmp_pls(pvn, (pq.size() > 0) ? pq.pop_front() : 11'h000);
  end

  task automatic chk_rst();
    for (int k = 0; k < 3; k++)
      for (int j = 0; j < 4; j++)
        chk(3'(j), 2'(k), (k == 2) ? 8'h7F : 8'hFF, 8'h00);
    chk(3'h4, 2'h0, 8'hFF, 8'h00);
    chk(3'h4, 2'h1, 8'h01, 8'h00);
  endtask

  // Random port setups; input-only control functions are kept as inputs, as software would
  task automatic lvl_test();
    logic [7:0] d, l, b, a, w, od, p2, p3;
    logic [7:0] m [3];
    logic [7:0] u [3];
    logic [7:0] oo [3];
    logic [7:0] xo [3];
    logic [7:0] pn [3];
    repeat (24)
    begin
      @(posedge CLK);
      for (int k = 0; k < 3; k++)
      begin
        od = (k == 2) ? 8'h08 : 8'h00;
        m[k] = rnd() & ((k == 2) ? 8'h1F : 8'hFF);
        d = rnd() | (m[k] & ~am[k]);
        l = rnd();
        u[k] = rnd();
        b = rnd();
        a = rnd();
        oo[k] = ~d & ~(l & od);
        xo[k] = ((m[k] & am[k] & a) | (~(m[k] & am[k]) & l)) & ~od;
        pn[k] = (oo[k] & xo[k]) | (~oo[k] & (u[k] | b));
        dir[k] <= d;
        pu[k] <= u[k];
        md[k] <= m[k];
        lt[k] <= l;
        be[k] <= ~oo[k] & ~u[k];
        bv[k] <= b;
        alt[k] <= a;
      end
      repeat (6) @(posedge CLK);
      for (int k = 0; k < 3; k++)
      begin
        od = (k == 2) ? 8'h08 : 8'h00;
        w = (k == 2) ? 8'h7F : 8'hFF;
        chk(3'h0, 2'(k), w, oo[k]);
        chk(3'h1, 2'(k), (oo[k] | od) & w, xo[k]);
        chk(3'h2, 2'(k), w, u[k]);
        chk(3'h3, 2'(k), w, pn[k]);
      end
      p2 = pn[1] & m[1];
      p3 = pn[2] & m[2];
      chk(3'h4, 2'h0, 8'hFF, {p2[0], p2[2], p2[4], p2[6], p2[3], p2[7], p2[6], p3[0]});
      chk(3'h4, 2'h1, 8'h01, {7'h00, p3[2]});
    end
  endtask

  // Moves one pad and notes the pulse it must cause, if any
  task automatic edge_on(input int k, input int i, input logic v, input logic [10:0] e);
    bv[k][i] <= v;
    if (e !== 11'h000)
      pq.push_back(e);
    repeat (8) @(posedge CLK);
  endtask

  task automatic pls_test();
    @(posedge CLK);
    dir[0] <= 8'hFF;
    md[0] <= 8'hFF;
    be[0] <= 8'hFF;
    bv[0] <= 8'h00;
    dir[2] <= 8'h7F;
    be[2] <= 8'h7F;
    bv[2] <= 8'h00;
    md[2] <= 8'h00;
    repeat (8) @(posedge CLK);
    for (int i = 0; i < 8; i++)
      for (int c = 0; c < 4; c++)
      begin
        sel <= 16'(c) << (2 * i);
        repeat (2) @(posedge CLK);
        edge_on(0, i, 1'b1, c[0] ? (11'h001 << i) : 11'h000);
        edge_on(0, i, 1'b0, c[1] ? (11'h001 << i) : 11'h000);
      end
    md[0] <= 8'h00;
    sel <= 16'hFFFF;
    repeat (4) @(posedge CLK);
    edge_on(0, 0, 1'b1, 11'h000);
    edge_on(0, 0, 1'b0, 11'h000);
    sel <= 16'h0000;
    for (int mm = 1; mm >= 0; mm--)
    begin
      md[2] <= (mm == 1) ? 8'h60 : 8'h00;
      repeat (4) @(posedge CLK);
      edge_on(2, 5, 1'b1, (mm == 1) ? 11'h700 : 11'h000);
      edge_on(2, 5, 1'b0, 11'h000);
      edge_on(2, 6, 1'b1, (mm == 1) ? 11'h200 : 11'h000);
      edge_on(2, 6, 1'b0, 11'h000);
    end
  endtask

  // Main sequence: reset, random setups, edge pulses, reset again in mid-run
  initial
  begin
    repeat (9) @(posedge CLK);
    chk_rst();
    @(posedge CLK);
    RSTN <= 1'b1;
    $display("Test reset done");
    lvl_test();
    $display("Test levels done");
    pls_test();
    $display("Test pulses done");
    RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    chk_rst();
    @(posedge CLK);
    RSTN <= 1'b1;
    repeat (10) @(posedge CLK);
    cmp_pls(11'(pq.size()), 11'h000);
    $display("Test second reset done");
    close_out();
  end

  // Watchdog: the whole sequence needs about 870 cycles
  initial
  begin
    repeat (6000) @(posedge CLK);
    err_count++;
    close_out();
  end
endmodule
